// File: design/sbc_slave.sv
// Sideband two-wire configuration access slave, SMBus read and I2C write.
// Summary of operation
// RL1: SMBus configuration access uses command code 08h after address write.
// RL2: SMBus offset byte gives register address bits seven to zero.
// RL3: SMBus port byte selects port zero to three; others reserved.
// RL4: SMBus read returns register bits 7:0 first, then bits 15:8.
// RL5: Master writes command, offset, port, then command again, restart read.
// RL6: Each byte is followed by one acknowledge bit, low acknowledges.
// RL7: I2C address is strap bits, bits three to five one, six zero.
// RL8: I2C write packet is address byte, command bytes, data bytes.
// RL9: Invalid I2C command leaves the target register unchanged.
// RL10: First I2C data byte is register byte three, then two, one, zero.
// RL11: Master always sends four data bytes regardless of byte enables.
// RL12: Master ends the write with stop or repeated start.
// RL13: Surplus I2C data bytes beyond four are not acknowledged.
// RL14: Packets open with start, bytes acknowledged, close with stop.
// RL15: Access works independently of the upstream link state.
// RL16: First command byte low three bits are command, 011b is write.
// RL17: Each byte enable set updates its register byte, clear leaves it.
// RL18: I2C register address is dword aligned, low two bits zero.
// RL19: SMBus address is strap bits, bits three, four, six one, five zero.
// RL20: Reserved SMBus port reads return zero and issue no access.
`timescale 1ns/1ps
`default_nettype none
module sbc_slave (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe,
    input  wire logic        serial_data_pin_in,
    output logic             serial_data_pin_out,
    output logic             serial_data_pin_oe,
    input  wire logic [2:0]  addr_strap,
    output logic             cfg_rd_req,
    output logic             cfg_wr_req,
    output logic [1:0]       cfg_port,
    output logic [11:0]      cfg_addr,
    output logic [3:0]       cfg_byte_en,
    output logic [31:0]      cfg_wdata,
    input  wire logic        cfg_rd_ack,
    input  wire logic [15:0] cfg_rdata
);
    sbc_line_if ln ();

    sbc_line_sync u_sync (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .scl_pin   (serial_clock_pin_in),
        .sda_pin   (serial_data_pin_in),
        .strap_pin (addr_strap),
        .ln        (ln)
    );

    sbc_pkg::sbc_state_e state;
    sbc_pkg::sbc_state_e next_state;
    logic [2:0]  bitcnt;
    logic [2:0]  next_bitcnt;
    logic [6:0]  shreg;
    logic [6:0]  next_shreg;
    logic [3:0]  idx;
    logic [3:0]  next_idx;
    logic        addr_phase;
    logic        next_addr_phase;
    logic        smb_mode;
    logic        next_smb_mode;
    logic        go_tx;
    logic        next_go_tx;
    logic        ack_ok;
    logic        next_ack_ok;
    logic        master_nak;
    logic        next_master_nak;
    logic        rd_pending;
    logic        next_rd_pending;
    logic [31:0] cmd;
    logic [31:0] next_cmd;
    logic [31:0] wdata;
    logic [31:0] next_wdata;
    logic [7:0]  smb_off;
    logic [7:0]  next_smb_off;
    logic [7:0]  smb_port;
    logic [7:0]  next_smb_port;
    logic [7:0]  txsh;
    logic [7:0]  next_txsh;
    logic [7:0]  txhi;
    logic [7:0]  next_txhi;
    logic        sda_oe;
    logic        next_sda_oe;
    logic        next_cfg_rd_req;
    logic        next_cfg_wr_req;
    logic [1:0]  next_cfg_port;
    logic [11:0] next_cfg_addr;
    logic [3:0]  next_cfg_byte_en;
    logic [31:0] next_cfg_wdata;
    logic [7:0]  rx_byte;

    always_comb begin
        next_state       = state;
        next_bitcnt      = bitcnt;
        next_shreg       = shreg;
        next_idx         = idx;
        next_addr_phase  = addr_phase;
        next_smb_mode    = smb_mode;
        next_go_tx       = go_tx;
        next_ack_ok      = ack_ok;
        next_master_nak  = master_nak;
        next_rd_pending  = rd_pending;
        next_cmd         = cmd;
        next_wdata       = wdata;
        next_smb_off     = smb_off;
        next_smb_port    = smb_port;
        next_txsh        = txsh;
        next_txhi        = txhi;
        next_sda_oe      = sda_oe;
        next_cfg_rd_req  = 1'b0;
        next_cfg_wr_req  = 1'b0;
        next_cfg_port    = cfg_port;
        next_cfg_addr    = cfg_addr;
        next_cfg_byte_en = cfg_byte_en;
        next_cfg_wdata   = cfg_wdata;
        rx_byte          = {shreg, ln.sda};

        // Read data is taken whenever it arrives; the engine has no
        // clock stretching, so it must come before the first data bit.
        if (cfg_rd_ack && rd_pending) begin
            next_rd_pending = 1'b0;
            next_txsh       = cfg_rdata[7:0];                    // [RL4]
            next_txhi       = cfg_rdata[15:8];                   // [RL4]
        end

        if (ln.stop_det) begin
            next_state  = sbc_pkg::ST_IDLE;                      // [RL14]
            next_sda_oe = 1'b0;
        end else if (ln.start_det) begin
            next_state      = sbc_pkg::ST_RX;                    // [RL14]
            next_addr_phase = 1'b1;
            next_bitcnt     = 3'h0;
            next_sda_oe     = 1'b0;
        end else begin
            case (state)
                sbc_pkg::ST_RX: begin
                    if (ln.scl_rise) begin
                        next_shreg = rx_byte[6:0];
                        if (bitcnt == sbc_pkg::BIT_LAST) begin
                            next_state      = sbc_pkg::ST_RX_HOLD;
                            next_addr_phase = 1'b0;
                            next_go_tx      = 1'b0;
                            next_ack_ok     = 1'b1;
                            if (addr_phase) begin
                                next_idx = 4'h0;
                                if (rx_byte[7:1] ==
                                    {sbc_pkg::SMB_ADDR_HI, ln.strap}) begin
                                    next_smb_mode = 1'b1;       // [RL19]
                                    if (rx_byte[0]) begin
                                        next_go_tx = 1'b1;      // [RL5]
                                        if (smb_port >
                                            sbc_pkg::PORT_LAST) begin
                                            next_txsh = 8'h00;  // [RL20]
                                            next_txhi = 8'h00;  // [RL20]
                                        end else begin
                                            next_cfg_rd_req = 1'b1;
                                            next_rd_pending = 1'b1;
                                            next_cfg_port   =
                                                smb_port[1:0]; // [RL3]
                                            next_cfg_addr   =
                                                {sbc_pkg::SMB_ADDR_PAD,
                                                 smb_off};      // [RL2]
                                        end
                                    end
                                end else if ((rx_byte[7:1] ==
                                    {sbc_pkg::I2C_ADDR_HI, ln.strap}) &&
                                    !rx_byte[0]) begin
                                    next_smb_mode = 1'b0;       // [RL7]
                                end else begin
                                    next_ack_ok = 1'b0;
                                end
                            end else begin
                                if (idx != sbc_pkg::IDX_MAX) begin
                                    next_idx = idx + 4'h1;
                                end
                                if (smb_mode) begin
                                    if (idx == sbc_pkg::IDX_SMB_CMD) begin
                                        next_ack_ok = (rx_byte ==
                                            sbc_pkg::SMB_CMD_CFG); // [RL1]
                                    end else if (idx ==
                                                 sbc_pkg::IDX_SMB_OFF) begin
                                        next_smb_off = rx_byte;  // [RL2]
                                    end else if (idx ==
                                                 sbc_pkg::IDX_SMB_PORT) begin
                                        next_smb_port = rx_byte; // [RL3]
                                    end
                                end else if (idx <=
                                             sbc_pkg::IDX_CMD_LAST) begin
                                    next_cmd = {cmd[23:0], rx_byte}; // [RL8]
                                end else if (idx <=
                                             sbc_pkg::IDX_DATA_LAST) begin
                                    // First data byte lands in bits 31:24.
                                    next_wdata = {wdata[23:0],
                                                  rx_byte}; // [RL10]
                                    if ((idx == sbc_pkg::IDX_DATA_LAST) &&
                                        (cmd[26:24] == // [RL16] [RL9]
                                         sbc_pkg::I2C_CMD_WRITE)) begin
                                        next_cfg_wr_req  = 1'b1; // [RL15]
                                        next_cfg_port    = {cmd[16], cmd[15]};
                                        next_cfg_byte_en =
                                            cmd[13:10]; // [RL17]
                                        next_cfg_addr    = {cmd[9:0],
                                            sbc_pkg::DWORD_PAD}; // [RL18]
                                        next_cfg_wdata   = {wdata[23:0],
                                                            rx_byte};
                                    end
                                end else begin
                                    next_ack_ok = 1'b0;         // [RL13]
                                end
                            end
                        end else begin
                            next_bitcnt = bitcnt + 3'h1;
                        end
                    end
                end
                sbc_pkg::ST_RX_HOLD: begin
                    if (ln.scl_fall) begin
                        next_sda_oe = ack_ok;                    // [RL6]
                        next_state  = sbc_pkg::ST_RX_ACK;
                    end
                end
                sbc_pkg::ST_RX_ACK: begin
                    if (ln.scl_fall) begin
                        next_bitcnt = 3'h0;
                        if (!ack_ok) begin
                            next_sda_oe = 1'b0;
                            next_state  = sbc_pkg::ST_WAIT;
                        end else if (go_tx) begin
                            next_sda_oe = ~txsh[7];
                            next_state  = sbc_pkg::ST_TX;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state  = sbc_pkg::ST_RX;
                        end
                    end
                end
                sbc_pkg::ST_TX: begin
                    if (ln.scl_fall) begin
                        if (bitcnt == sbc_pkg::BIT_LAST) begin
                            next_sda_oe = 1'b0;
                            next_bitcnt = 3'h0;
                            next_state  = sbc_pkg::ST_TX_ACK;
                        end else begin
                            next_bitcnt = bitcnt + 3'h1;
                            next_txsh   = {txsh[6:0], 1'b0};
                            next_sda_oe = ~txsh[6];
                        end
                    end
                end
                sbc_pkg::ST_TX_ACK: begin
                    if (ln.scl_rise) begin
                        next_master_nak = ln.sda;                // [RL6]
                    end
                    if (ln.scl_fall) begin
                        if (master_nak) begin
                            next_state = sbc_pkg::ST_WAIT;
                        end else begin
                            // Bytes past the second one read as zero.
                            next_txsh   = txhi;                  // [RL4]
                            next_txhi   = 8'h00;
                            next_sda_oe = ~txhi[7];
                            next_state  = sbc_pkg::ST_TX;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state       <= sbc_pkg::ST_IDLE;
            bitcnt      <= 3'h0;
            shreg       <= 7'h00;
            idx         <= 4'h0;
            addr_phase  <= 1'b0;
            smb_mode    <= 1'b0;
            go_tx       <= 1'b0;
            ack_ok      <= 1'b0;
            master_nak  <= 1'b0;
            rd_pending  <= 1'b0;
            cmd         <= 32'h0000_0000;
            wdata       <= 32'h0000_0000;
            smb_off     <= 8'h00;
            smb_port    <= 8'h00;
            txsh        <= 8'h00;
            txhi        <= 8'h00;
            sda_oe      <= 1'b0;
            cfg_rd_req  <= 1'b0;
            cfg_wr_req  <= 1'b0;
            cfg_port    <= 2'h0;
            cfg_addr    <= 12'h000;
            cfg_byte_en <= 4'h0;
            cfg_wdata   <= 32'h0000_0000;
        end else begin
            state       <= next_state;
            bitcnt      <= next_bitcnt;
            shreg       <= next_shreg;
            idx         <= next_idx;
            addr_phase  <= next_addr_phase;
            smb_mode    <= next_smb_mode;
            go_tx       <= next_go_tx;
            ack_ok      <= next_ack_ok;
            master_nak  <= next_master_nak;
            rd_pending  <= next_rd_pending;
            cmd         <= next_cmd;
            wdata       <= next_wdata;
            smb_off     <= next_smb_off;
            smb_port    <= next_smb_port;
            txsh        <= next_txsh;
            txhi        <= next_txhi;
            sda_oe      <= next_sda_oe;
            cfg_rd_req  <= next_cfg_rd_req;
            cfg_wr_req  <= next_cfg_wr_req;
            cfg_port    <= next_cfg_port;
            cfg_addr    <= next_cfg_addr;
            cfg_byte_en <= next_cfg_byte_en;
            cfg_wdata   <= next_cfg_wdata;
        end
    end

    // Open-drain lines: the data level is always low when enabled, and the
    // clock line is never driven because this slave does not stretch.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            serial_data_pin_out  <= 1'b0;
            serial_data_pin_oe   <= 1'b0;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
        end else begin
            serial_data_pin_out  <= 1'b0;
            serial_data_pin_oe   <= next_sda_oe;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: design/sbc_pkg.sv
// Constants and types shared by the sideband configuration access slave.
package sbc_pkg;
    // Upper four bits of the two seven-bit slave addresses.
    localparam logic [3:0]  SMB_ADDR_HI   = 4'hb;
    localparam logic [3:0]  I2C_ADDR_HI   = 4'h7;
    localparam logic [7:0]  SMB_CMD_CFG   = 8'h08;
    localparam logic [2:0]  I2C_CMD_WRITE = 3'h3;
    localparam logic [7:0]  PORT_LAST     = 8'h03;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    // Byte indices after the address byte.
    localparam logic [3:0]  IDX_SMB_CMD   = 4'h0;
    localparam logic [3:0]  IDX_SMB_OFF   = 4'h1;
    localparam logic [3:0]  IDX_SMB_PORT  = 4'h2;
    localparam logic [3:0]  IDX_CMD_LAST  = 4'h3;
    localparam logic [3:0]  IDX_DATA_LAST = 4'h7;
    localparam logic [3:0]  IDX_MAX       = 4'hf;
    localparam logic [3:0]  SMB_ADDR_PAD  = 4'h0;
    localparam logic [1:0]  DWORD_PAD     = 2'h0;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_RX      = 7'h02,
        ST_RX_HOLD = 7'h04,
        ST_RX_ACK  = 7'h08,
        ST_TX      = 7'h10,
        ST_TX_ACK  = 7'h20,
        ST_WAIT    = 7'h40
    } sbc_state_e;
endpackage

// File: design/sbc_line_if.sv
// Synchronised line events passed from the pin front end to the protocol.
`timescale 1ns/1ps
`default_nettype none
interface sbc_line_if;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       sda;
    logic [2:0] strap;

    modport front (output scl_rise, scl_fall, start_det, stop_det, sda, strap);
    modport proto (input  scl_rise, scl_fall, start_det, stop_det, sda, strap);
endinterface
`default_nettype wire

// File: design/sbc_line_sync.sv
// Pin synchronisers and start, stop and clock edge detection.
`timescale 1ns/1ps
`default_nettype none
module sbc_line_sync (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    input  wire logic [2:0] strap_pin,
    sbc_line_if.front       ln
);
    // Stage one feeds stage two only; stage three is the delayed copy.
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [2:0] strap1;
    logic [2:0] strap2;
    logic [1:0] next_s1;
    logic [1:0] next_s2;
    logic [1:0] next_s3;

    always_comb begin
        next_s1 = {scl_pin, sda_pin};
        next_s2 = s1;
        next_s3 = s2;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s1     <= 2'h3;
            s2     <= 2'h3;
            s3     <= 2'h3;
            strap1 <= 3'h0;
            strap2 <= 3'h0;
        end else begin
            s1     <= next_s1;
            s2     <= next_s2;
            s3     <= next_s3;
            strap1 <= strap_pin;
            strap2 <= strap1;
        end
    end

    // Both lines share one delay, so data moving with clock high is seen true.
    assign ln.scl_rise  = s2[1] & ~s3[1];
    assign ln.scl_fall  = ~s2[1] & s3[1];
    assign ln.start_det = s2[1] & s3[1] & ~s2[0] & s3[0]; // [RL14]
    assign ln.stop_det  = s2[1] & s3[1] & s2[0] & ~s3[0]; // [RL14]
    assign ln.sda       = s2[0];
    assign ln.strap     = strap2;
endmodule
`default_nettype wire

// File: bench/sbc_slave_assertions.sv
// Checker bound to the sideband slave top, watching its ports only.
`timescale 1ns/1ps
`default_nettype none
module sbc_slave_assertions (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        serial_clock_pin_in,
    input  wire logic        serial_clock_pin_out,
    input  wire logic        serial_clock_pin_oe,
    input  wire logic        serial_data_pin_out,
    input  wire logic        serial_data_pin_oe,
    input  wire logic        cfg_rd_req,
    input  wire logic        cfg_wr_req,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_byte_en,
    input  wire logic [31:0] cfg_wdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    no_clk_drive_a: assert property (
        !serial_clock_pin_oe && !serial_clock_pin_out)
        else $error("serial clock pin driven");
    data_low_only_a: assert property (!serial_data_pin_out)
        else $error("data pin driven high");
    req_excl_a: assert property (!(cfg_rd_req && cfg_wr_req))
        else $error("read and write requested together");
    rd_addr_hi_a: assert property (
        cfg_rd_req |-> cfg_addr[11:8] == 4'h0)
        else $error("read address above offset byte");
    wr_align_a: assert property (
        cfg_wr_req |-> cfg_addr[1:0] == 2'h0)
        else $error("write address not dword aligned");
    wr_gap_a: assert property (cfg_wr_req |=> !cfg_wr_req [*8])
        else $error("write request repeated too soon");
    wdata_hold_a: assert property (
        !cfg_wr_req |-> $stable(cfg_wdata) && $stable(cfg_byte_en))
        else $error("write fields moved without a request");
    oe_rise_a: assert property (
        $rose(serial_data_pin_oe) |-> !$past(serial_clock_pin_in, 3))
        else $error("data drive began outside clock low");
    oe_fall_a: assert property (
        $fell(serial_data_pin_oe) |->
            !serial_clock_pin_in && !$past(serial_clock_pin_in))
        else $error("data drive released while clock high");
endmodule
bind sbc_slave sbc_slave_assertions u_sva (
    .core_clk(core_clk), .resetn(resetn),
    .serial_clock_pin_in(serial_clock_pin_in),
    .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe(serial_clock_pin_oe),
    .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe(serial_data_pin_oe),
    .cfg_rd_req(cfg_rd_req), .cfg_wr_req(cfg_wr_req),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata)
);
`default_nettype wire

// File: bench/sbc_bus_master.sv
// Bit-level two-wire bus master model driving open-drain enables.
`timescale 1ns/1ps
`default_nettype none
module sbc_bus_master (
    input  wire logic core_clk,
    input  wire logic sda_line,
    output logic      scl_oe,
    output logic      sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // A quarter of the 160 ns bus clock period.
    task automatic q();
        repeat (2) @(negedge core_clk);
    endtask
    // Data only moves while the clock is low, except start and stop.
    task automatic bit_x(input logic b, output logic s);
        q();
        sda_oe = ~b;
        q();
        scl_oe = 1'b0;
        q();
        s = sda_line;
        q();
        scl_oe = 1'b1;
    endtask
    task automatic start();
        q();
        q();
        sda_oe = 1'b0;
        q();
        scl_oe = 1'b0;
        q();
        sda_oe = 1'b1;
        q();
        scl_oe = 1'b1;
    endtask
    task automatic stop();
        q();
        sda_oe = 1'b1;
        q();
        scl_oe = 1'b0;
        q();
        sda_oe = 1'b0;
        q();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], nak);
        bit_x(1'b1, nak);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, last);
    endtask
endmodule
`default_nettype wire

// File: bench/sbc_slave_bench.sv
// Self-checking bench for the sideband configuration access slave.
`timescale 1ns/1ps
`default_nettype none
module sbc_slave_bench;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [2:0]  addr_strap = 3'h5;
    logic        cfg_rd_ack = 1'b0;
    logic [15:0] cfg_rdata = 16'h0000;
    logic        m_scl, m_sda, s_scl, s_sda, scl_w, sda_w;
    logic        cfg_rd_req, cfg_wr_req;
    logic [1:0]  cfg_port;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_byte_en;
    logic [31:0] cfg_wdata;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          rd_cnt = 0;
    int          wr_cnt = 0;
    int          cyc = 0;
    // Both wires have pull-ups; any party's enable pulls them low.
    assign scl_w = ~(m_scl | s_scl);
    assign sda_w = ~(m_sda | s_sda);
    always #10 core_clk = ~core_clk;
    sbc_bus_master host (.core_clk(core_clk), .sda_line(sda_w),
        .scl_oe(m_scl), .sda_oe(m_sda));
    sbc_slave uut (.core_clk(core_clk), .resetn(resetn),
        .serial_clock_pin_in(scl_w), .serial_clock_pin_out(),
        .serial_clock_pin_oe(s_scl), .serial_data_pin_in(sda_w),
        .serial_data_pin_out(), .serial_data_pin_oe(s_sda),
        .addr_strap(addr_strap), .cfg_rd_req(cfg_rd_req),
        .cfg_wr_req(cfg_wr_req), .cfg_port(cfg_port),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rd_ack(cfg_rd_ack),
        .cfg_rdata(cfg_rdata));
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // Read data is only valid with the acknowledge; it churns otherwise.
    // Requests are counted away from their launching edge, and each read
    // is answered on the same falling edge that counts its request.
    always @(negedge core_clk) begin
        if (cfg_wr_req === 1'b1) wr_cnt++;
        if (cfg_rd_req === 1'b1) begin
            rd_cnt++;
            cfg_rd_ack = 1'b1;
            cfg_rdata = {6'h2a, cfg_port, cfg_addr[7:0]};
        end else begin
            cfg_rd_ack = 1'b0;
            cfg_rdata = ~cfg_rdata;
        end
    end
    task automatic check(input string nm, input logic [49:0] e,
                         input logic [49:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic smb_read(input logic [7:0] cmd, input logic [7:0] off,
                            input logic [7:0] pt, output logic [6:0] nk,
                            output logic [15:0] d);
        logic [55:0] b;
        b = {8'hba, cmd, off, pt, 8'hba, cmd, 8'hbb};
        host.start();
        for (int i = 6; i >= 0; i--) begin
            if (i == 2) host.stop();
            if (i == 2 || i == 0) host.start();
            host.wbyte(b[i*8+:8], nk[i]);
        end
        host.rbyte(1'b0, d[7:0]);
        host.rbyte(1'b1, d[15:8]);
        host.stop();
    endtask
    task automatic i2c_write(input logic [31:0] c, input logic [31:0] w,
                             output logic [9:0] nk);
        logic [79:0] b;
        b = {8'h7a, c, w, 8'h9a};
        host.start();
        for (int i = 9; i >= 0; i--) host.wbyte(b[i*8+:8], nk[i]);
        host.stop();
    endtask
    task automatic t_i2c_codes();
        logic [9:0] nk;
        int         n;
        for (int k = 0; k < 8; k++) begin
            n = wr_cnt;
            i2c_write({5'h1f, 3'(k), 24'h003c2d}, 32'h12345678, nk);
            check("i2c acks", 50'h1, 50'(nk));
            check("i2c reqs", 50'(n + (k == 3)), 50'(wr_cnt));
        end
        check("i2c held", {2'h0, 12'h0b4, 4'hf, 32'h12345678},
            {cfg_port, cfg_addr, cfg_byte_en, cfg_wdata});
    endtask
    task automatic t_i2c_fields();
        logic [9:0] nk;
        i2c_write(32'h030196ff, 32'hdeadbeef, nk);
        check("i2c fields", {2'h3, 12'hbfc, 4'h5, 32'hdeadbeef},
            {cfg_port, cfg_addr, cfg_byte_en, cfg_wdata});
    endtask
    task automatic t_smb_reads();
        logic [6:0]  nk;
        logic [15:0] d;
        logic [7:0]  offs [4];
        int          n;
        offs = '{8'h00, 8'hb4, 8'hff, 8'h5a};
        for (int p = 0; p < 4; p++) begin
            n = rd_cnt;
            smb_read(8'h08, offs[p], 8'(p), nk, d);
            check("smb acks", 50'h0, 50'(nk));
            check("smb data", 50'({6'h2a, 2'(p), offs[p]}), 50'(d));
            check("smb addr", 50'({4'h0, offs[p]}), 50'(cfg_addr));
            check("smb reqs", 50'(n + 1), 50'(rd_cnt));
        end
    endtask
    task automatic t_smb_refused();
        logic [6:0]  nk;
        logic [15:0] d;
        int          n;
        n = rd_cnt;
        smb_read(8'h08, 8'hb4, 8'h04, nk, d);
        check("resv data", 50'h0, 50'(d));
        check("resv reqs", 50'(n), 50'(rd_cnt));
        smb_read(8'h07, 8'hb4, 8'h01, nk, d);
        check("bad cmd nak", 50'h1, 50'(nk[5]));
        host.start();
        host.wbyte(8'hb8, nk[0]);
        host.wbyte(8'h7b, nk[1]);
        host.stop();
        host.start();
        host.wbyte(8'h7b, nk[2]);
        host.stop();
        check("addr naks", 50'h7, 50'(nk[2:0]));
        addr_strap = 3'h2;
        host.start();
        host.wbyte(8'hb4, nk[3]);
        host.stop();
        addr_strap = 3'h5;
        check("strap ack", 50'h0, 50'(nk[3]));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        t_i2c_codes();
        t_i2c_fields();
        t_smb_reads();
        t_smb_refused();
        tally_and_finish();
    end
endmodule
`default_nettype wire
